/* File: design/bitop_pkg.sv */
/*
  Constants and types shared by the bit-manipulation datapath and its field helper.
  Assumes an 8-bit byte operand and a byte-wide memory operand path.
*/
package bitop_pkg;

  localparam int BYTE_W = 8;
  localparam int BITSEL_W = 3;
  localparam int ADDR_W = 24;

  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h000000;
  localparam logic [BITSEL_W-1:0] BITSEL_ZERO = 3'h0;

  // Operation codes presented on the request port.
  typedef enum logic [3:0] {
    bit_inverse_xor_to_carry,
    bit_load_to_carry,
    bit_inverse_load_to_carry,
    bit_store_from_carry,
    bit_store_from_zero,
    bit_inverse_store_from_carry,
    bit_inverse_store_from_zero,
    bit_field_load,
    bit_field_store
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_WRITE,
    ST_FAULT
  } fsm_t;

endpackage

/* File: design/bit_field_unit.sv */
/*
  Bit-field extract and insert for one byte, steered by a field mask.
  Assumes the mask marks one contiguous field; purely combinational.
*/
`timescale 1ns/1ps
module bit_field_unit (
  // Operands
  input wire logic [bitop_pkg::BYTE_W-1:0] field_mask,
  input wire logic [bitop_pkg::BYTE_W-1:0] mem_byte,
  input wire logic [bitop_pkg::BYTE_W-1:0] reg_byte,
  // Results
  output logic [bitop_pkg::BYTE_W-1:0] extracted,
  output logic [bitop_pkg::BYTE_W-1:0] inserted
);
  import bitop_pkg::*;

  // An empty mask yields position zero, so extract gives zero and insert changes nothing.
  function automatic logic [BITSEL_W-1:0] lowest_set(input logic [BYTE_W-1:0] m);
    logic [BITSEL_W-1:0] pos;
    pos = BITSEL_ZERO;
    for (int i = BYTE_W - 1; i >= 0; i--) begin
      if (m[i]) begin
        pos = BITSEL_W'(i);
      end
    end
    return pos;
  endfunction

  logic [BITSEL_W-1:0] shift;

  always_comb begin
    shift = lowest_set(field_mask);
    extracted = (mem_byte & field_mask) >> shift;
    inserted = (mem_byte & ~field_mask) | ((reg_byte << shift) & field_mask);
  end

endmodule

/* File: design/bit_manip_unit.sv */
/*
  Single-bit and bit-field instruction datapath of the CPU core.
  Register operands arrive with the request; memory operands are fetched, and for stores written
  back, over a simple held-request byte port that runs on the same clock.
*/
`timescale 1ns/1ps
module bit_manip_unit (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Request from the instruction sequencer
  input wire logic req_valid,
  input wire bitop_pkg::op_t req_op,
  input wire logic [bitop_pkg::BITSEL_W-1:0] req_bit,
  input wire logic [bitop_pkg::BYTE_W-1:0] req_mask,
  input wire logic req_use_mem,
  input wire logic [bitop_pkg::ADDR_W-1:0] req_addr,
  input wire logic [bitop_pkg::BYTE_W-1:0] req_reg_data,
  input wire logic flag_c,
  input wire logic flag_z,
  output logic req_ready,
  // Completion toward register file and condition flags
  output logic done,
  output logic illegal,
  output logic carry_we,
  output logic carry_out,
  output logic reg_we,
  output logic [bitop_pkg::BYTE_W-1:0] reg_wdata,
  // Memory operand path
  output logic mem_rd,
  output logic mem_wr,
  output logic [bitop_pkg::ADDR_W-1:0] mem_addr,
  output logic [bitop_pkg::BYTE_W-1:0] mem_wdata,
  input wire logic mem_rvalid,
  input wire logic [bitop_pkg::BYTE_W-1:0] mem_rdata,
  input wire logic mem_wack
);
  import bitop_pkg::*;

  typedef struct packed {
    fsm_t st;
    op_t op;
    logic [BITSEL_W-1:0] bitn;
    logic [BYTE_W-1:0] mask;
    logic use_mem;
    logic [BYTE_W-1:0] reg_byte;
    logic [BYTE_W-1:0] opnd;
    logic c;
    logic z;
    logic ready;
    logic done;
    logic illegal;
    logic carry_we;
    logic carry_out;
    logic reg_we;
    logic [BYTE_W-1:0] reg_wdata;
    logic mem_rd;
    logic mem_wr;
    logic [ADDR_W-1:0] mem_addr;
    logic [BYTE_W-1:0] mem_wdata;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  logic [BYTE_W-1:0] field_extract;
  logic [BYTE_W-1:0] field_insert;

  bit_field_unit u_field (
    .field_mask(state_r.mask),
    .mem_byte(state_r.opnd),
    .reg_byte(state_r.reg_byte),
    .extracted(field_extract),
    .inserted(field_insert)
  );

  // Zero-flag stores and both field operations have no register form.
  function automatic logic needs_memory(input op_t op);
    return (op == bit_store_from_zero) || (op == bit_inverse_store_from_zero) ||
           (op == bit_field_load) || (op == bit_field_store);
  endfunction

  function automatic logic is_bit_store(input op_t op);
    return (op == bit_store_from_carry) || (op == bit_store_from_zero) ||
           (op == bit_inverse_store_from_carry) || (op == bit_inverse_store_from_zero);
  endfunction

  // Replaces exactly one bit so the rest of the byte survives the write-back.
  function automatic logic [BYTE_W-1:0] put_bit(input logic [BYTE_W-1:0] b,
                                                input logic [BITSEL_W-1:0] n,
                                                input logic v);
    logic [BYTE_W-1:0] r;
    r = b;
    r[n] = v;
    return r;
  endfunction

  logic sel_bit;
  logic store_val;
  logic [BYTE_W-1:0] store_byte;

  always_comb begin
    state_nxt = state_r;
    state_nxt.done = 1'b0;
    state_nxt.illegal = 1'b0;
    state_nxt.carry_we = 1'b0;
    state_nxt.reg_we = 1'b0;
    sel_bit = state_r.opnd[state_r.bitn];
    store_val = 1'b0;
    case (state_r.op)
      bit_store_from_carry: store_val = state_r.c;
      bit_store_from_zero: store_val = state_r.z;
      bit_inverse_store_from_carry: store_val = ~state_r.c;
      bit_inverse_store_from_zero: store_val = ~state_r.z;
      default: store_val = 1'b0;
    endcase
    store_byte = (state_r.op == bit_field_store) ? field_insert
                 : put_bit(state_r.opnd, state_r.bitn, store_val);

    case (state_r.st)
      ST_IDLE: begin
        if (req_valid) begin
          state_nxt.op = req_op;
          state_nxt.bitn = req_bit;
          state_nxt.mask = req_mask;
          state_nxt.use_mem = req_use_mem;
          state_nxt.reg_byte = req_reg_data;
          state_nxt.opnd = req_reg_data;
          state_nxt.c = flag_c;
          state_nxt.z = flag_z;
          state_nxt.mem_addr = req_addr;
          if (needs_memory(req_op) && !req_use_mem) begin
            state_nxt.st = ST_FAULT;
          end else if (req_use_mem) begin
            state_nxt.mem_rd = 1'b1;
            state_nxt.st = ST_READ;
          end else begin
            state_nxt.st = ST_EXEC;
          end
        end
      end
      ST_READ: begin
        if (mem_rvalid) begin
          state_nxt.mem_rd = 1'b0;
          state_nxt.opnd = mem_rdata;
          state_nxt.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (is_bit_store(state_r.op) || state_r.op == bit_field_store) begin
          if (state_r.use_mem) begin
            state_nxt.mem_wr = 1'b1;
            state_nxt.mem_wdata = store_byte;
            state_nxt.st = ST_WRITE;
          end else begin
            state_nxt.reg_we = 1'b1;
            state_nxt.reg_wdata = store_byte;
            state_nxt.done = 1'b1;
            state_nxt.st = ST_IDLE;
          end
        end else if (state_r.op == bit_field_load) begin
          state_nxt.reg_we = 1'b1;
          state_nxt.reg_wdata = field_extract;
          state_nxt.done = 1'b1;
          state_nxt.st = ST_IDLE;
        end else begin
          // Carry-only forms never write the operand back and touch no other flag.
          state_nxt.carry_we = 1'b1;
          case (state_r.op)
            bit_inverse_xor_to_carry: state_nxt.carry_out = state_r.c ^ ~sel_bit;
            bit_load_to_carry: state_nxt.carry_out = sel_bit;
            bit_inverse_load_to_carry: state_nxt.carry_out = ~sel_bit;
            default: state_nxt.carry_out = state_r.c;
          endcase
          state_nxt.done = 1'b1;
          state_nxt.st = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (mem_wack) begin
          state_nxt.mem_wr = 1'b0;
          state_nxt.done = 1'b1;
          state_nxt.st = ST_IDLE;
        end
      end
      ST_FAULT: begin
        state_nxt.illegal = 1'b1;
        state_nxt.done = 1'b1;
        state_nxt.st = ST_IDLE;
      end
      default: begin
        state_nxt.st = ST_IDLE;
      end
    endcase
    state_nxt.ready = (state_nxt.st == ST_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_r <= '0;
      state_r.st <= ST_IDLE;
      state_r.op <= bit_load_to_carry;
      state_r.bitn <= BITSEL_ZERO;
      state_r.mask <= BYTE_ZERO;
      state_r.reg_byte <= BYTE_ZERO;
      state_r.opnd <= BYTE_ZERO;
      state_r.ready <= 1'b1;
      state_r.reg_wdata <= BYTE_ZERO;
      state_r.mem_addr <= ADDR_ZERO;
      state_r.mem_wdata <= BYTE_ZERO;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign req_ready = state_r.ready;
  assign done = state_r.done;
  assign illegal = state_r.illegal;
  assign carry_we = state_r.carry_we;
  assign carry_out = state_r.carry_out;
  assign reg_we = state_r.reg_we;
  assign reg_wdata = state_r.reg_wdata;
  assign mem_rd = state_r.mem_rd;
  assign mem_wr = state_r.mem_wr;
  assign mem_addr = state_r.mem_addr;
  assign mem_wdata = state_r.mem_wdata;

endmodule

/* File: verif/bit_manip_unit_props.sv */
/* Port checker for the bit datapath.
   Assumes it is bound onto bit_manip_unit and sees only its ports. */
`timescale 1ns/1ps
module bit_manip_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Request
  input wire logic req_valid,
  input wire bitop_pkg::op_t req_op,
  input wire logic req_use_mem,
  input wire logic req_ready,
  // Completion
  input wire logic done,
  input wire logic illegal,
  input wire logic carry_we,
  input wire logic reg_we,
  // Memory path
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [bitop_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [bitop_pkg::BYTE_W-1:0] mem_wdata,
  input wire logic mem_rvalid,
  input wire logic mem_wack
);
  import bitop_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic take = req_valid && req_ready;
  wire logic mem_only = req_op inside {bit_store_from_zero, bit_inverse_store_from_zero,
    bit_field_load, bit_field_store};
  refuse_reg_a: assert property (take && !req_use_mem && mem_only |->
    ##2 (done && illegal && !reg_we)) else $error("register form not refused");
  no_mem_a: assert property (take && !req_use_mem |=> !mem_rd ##1 !mem_rd)
    else $error("memory read for register operand");
  reg_lat_a: assert property (take && !req_use_mem && !mem_only |-> ##2 done)
    else $error("register operation late");
  rd_hold_a: assert property (mem_rd && !mem_rvalid |=> mem_rd && $stable(mem_addr))
    else $error("read request dropped");
  wr_hold_a: assert property (mem_wr && !mem_wack |=> mem_wr && $stable(mem_wdata))
    else $error("write request dropped");
  wr_done_a: assert property (mem_wr && mem_wack |=> done && !mem_wr)
    else $error("store did not complete");
  rd_end_a: assert property (mem_rd && mem_rvalid |=> !mem_rd && !mem_wr)
    else $error("read not released");
  carry_only_a: assert property (carry_we |-> !reg_we && !illegal && !mem_wr)
    else $error("carry operation wrote operand");
  illegal_quiet_a: assert property (illegal |-> done && !carry_we)
    else $error("refused request changed carry");
  cover property (illegal);
  cover property (carry_we);
  cover property (mem_wr && mem_wack);
  cover property (reg_we && !mem_wr);
endmodule

/* File: verif/mem_model.sv */
/* Byte memory behind the operand path, sixteen cells.
   Assumes the bench sets the wait count between requests only. */
`timescale 1ns/1ps
module mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Wait cycles before each answer
  input wire logic [1:0] lat,
  // Memory path
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [bitop_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [bitop_pkg::BYTE_W-1:0] mem_wdata,
  output logic mem_rvalid,
  output logic [bitop_pkg::BYTE_W-1:0] mem_rdata,
  output logic mem_wack
);
  import bitop_pkg::*;
  logic [BYTE_W-1:0] mem [16];
  logic [1:0] cnt_r;
  // Read data toggles outside valid cycles so a late sample is caught.
  always @(posedge clk_sys) begin
    mem_rvalid <= 1'b0;
    mem_wack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_b) begin
      cnt_r <= 2'h0;
      mem_rdata <= 8'h00;
    end else if ((mem_rd || mem_wr) && !mem_rvalid && !mem_wack) begin
      cnt_r <= cnt_r + 2'h1;
      if (cnt_r == lat) begin
        cnt_r <= 2'h0;
        mem_rvalid <= mem_rd;
        mem_wack <= mem_wr;
        if (mem_rd) mem_rdata <= mem[mem_addr[3:0]];
        else mem[mem_addr[3:0]] <= mem_wdata;
      end
    end
  end
endmodule

/* File: verif/bit_manip_unit_bench.sv */
/* Self-checking bench for bit_manip_unit with a memory model.
   Assumes inputs change on the falling clock edge only. */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t mismatch %h %h", $time, a, b); end end
module bit_manip_unit_bench;
  import bitop_pkg::*;
  logic clk_sys, rst_b, req_valid, req_use_mem, flag_c, flag_z, req_ready, done, illegal;
  logic carry_we, carry_out, reg_we, mem_rd, mem_wr, mem_rvalid, mem_wack;
  logic c_we, c_out, r_we, ill;
  op_t req_op;
  logic [2:0] req_bit;
  logic [1:0] lat;
  logic [7:0] req_mask, req_reg_data, reg_wdata, mem_wdata, mem_rdata, r_wd;
  logic [23:0] req_addr, mem_addr;
  int failures, compares;
  bit_manip_unit dut (.*);
  mem_model mdl (.*);
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic run(op_t op, int b, logic [7:0] m, logic um, logic [7:0] d, logic c, logic z);
    int n;
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_op = op;
    {req_bit, req_mask, req_use_mem} = {b[2:0], m, um};
    {req_addr, req_reg_data, flag_c, flag_z} = {21'h000000, b[2:0], d, c, z};
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    if (done !== 1'b1) begin
      failures++;
      $display("[ERR] %0t request never completed", $time);
      close_out();
    end
    {c_we, c_out, r_we, r_wd, ill} = {carry_we, carry_out, reg_we, reg_wdata, illegal};
  endtask
  task automatic t_carry();
    logic [7:0] d = 8'hA5;
    for (int b = 0; b < 8; b++) begin
      run(bit_load_to_carry, b, 8'h00, 1'b0, d, 1'b0, 1'b0);
      `CHK(c_out, d[b])
      run(bit_inverse_load_to_carry, b, 8'h00, 1'b0, d, 1'b0, 1'b0);
      `CHK(c_out, ~d[b])
      run(bit_inverse_xor_to_carry, b, 8'h00, 1'b0, d, b[0], 1'b0);
      `CHK({c_we, r_we, c_out}, {2'b10, b[0] ^ ~d[b]})
    end
    mdl.mem[3] = 8'h08;
    lat = 2'h3;
    run(bit_inverse_xor_to_carry, 3, 8'h00, 1'b1, 8'h00, 1'b1, 1'b0);
    `CHK({c_out, mdl.mem[3]}, {1'b1, 8'h08})
    $display("carry test ended");
  endtask
  task automatic t_store();
    logic [7:0] d = 8'h5A;
    logic [7:0] e;
    for (int b = 0; b < 8; b++) begin
      e = d;
      e[b] = b[0];
      run(bit_store_from_carry, b, 8'h00, 1'b0, d, b[0], 1'b0);
      `CHK({r_we, r_wd}, {1'b1, e})
      e[b] = ~b[0];
      run(bit_inverse_store_from_carry, b, 8'h00, 1'b0, d, b[0], 1'b0);
      `CHK({r_we, r_wd}, {1'b1, e})
      mdl.mem[b] = d;
      e[b] = b[1];
      lat = b[2:1];
      run(bit_store_from_zero, b, 8'h00, 1'b1, 8'h00, 1'b0, b[1]);
      `CHK(mdl.mem[b], e)
      mdl.mem[b] = d;
      e[b] = ~b[1];
      run(bit_inverse_store_from_zero, b, 8'h00, 1'b1, 8'h00, 1'b0, b[1]);
      `CHK(mdl.mem[b], e)
    end
    mdl.mem[5] = 8'hFF;
    run(bit_store_from_carry, 5, 8'h00, 1'b1, 8'h00, 1'b0, 1'b1);
    `CHK({r_we, mdl.mem[5]}, {1'b0, 8'hDF})
    mdl.mem[6] = 8'h00;
    run(bit_inverse_store_from_carry, 6, 8'h00, 1'b1, 8'h00, 1'b0, 1'b0);
    `CHK({r_we, mdl.mem[6]}, {1'b0, 8'h40})
    $display("store test ended");
  endtask
  task automatic t_field();
    mdl.mem[0] = 8'hD6;
    mdl.mem[1] = 8'hC3;
    run(bit_field_load, 0, 8'h38, 1'b1, 8'hFF, 1'b0, 1'b0);
    `CHK({r_we, r_wd}, {1'b1, 8'h02})
    run(bit_field_store, 1, 8'h3C, 1'b1, 8'h09, 1'b0, 1'b0);
    `CHK(mdl.mem[1], 8'hE7)
    $display("field test ended");
  endtask
  task automatic t_refuse();
    op_t ops[4] = '{bit_store_from_zero, bit_inverse_store_from_zero, bit_field_load,
      bit_field_store};
    foreach (ops[i]) begin
      run(ops[i], i, 8'h0F, 1'b0, 8'hFF, 1'b1, 1'b1);
      `CHK({ill, r_we, c_we}, 3'b100)
    end
    $display("refuse test ended");
  endtask
  // A reset while the operand read of a memory store is pending must drop the read and clear outputs.
  task automatic t_reset();
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_op = bit_store_from_carry;
    req_use_mem = 1'b1;
    lat = 2'h3;
    @(negedge clk_sys);
    req_valid = 1'b0;
    `CHK({req_ready, mem_rd}, 2'b01)
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK({req_ready, done, mem_rd, mem_wr, carry_out, reg_wdata}, {5'b10000, 8'h00})
    rst_b = 1'b1;
    run(bit_load_to_carry, 7, 8'h00, 1'b0, 8'h80, 1'b0, 1'b0);
    `CHK({c_we, c_out}, 2'b11)
    $display("reset test ended");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_b, req_valid, req_use_mem, flag_c, flag_z, lat} = 7'h00;
    req_op = bit_load_to_carry;
    {req_bit, req_mask, req_addr, req_reg_data} = 43'h0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    t_carry();
    t_store();
    t_field();
    t_reset();
    t_refuse();
    close_out();
  end
endmodule
bind bit_manip_unit bit_manip_checker chk (.*);
